/* design/iowdt_decode.sv */
// module: host io read address decoder
`timescale 1ns/1ns
module iowdt_decode
(
  input  wire logic                         clock_i,
  input  wire logic                         reset_i,
  input  wire logic [iowdt_pkg::ADDR_W-1:0] io_addr_i,
  input  wire logic                         io_read_n_i,
  iowdt_if.dec                              ev
);
  import iowdt_pkg::*;

  logic [ADDR_W-1:0] addr_s1_reg;
  logic [ADDR_W-1:0] addr_s2_reg;
  logic [2:0]        rd_sync_reg;

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      addr_s1_reg <= '0;
      addr_s2_reg <= '0;
      rd_sync_reg <= 3'h7;
    end
    else
    begin
      addr_s1_reg <= io_addr_i;
      addr_s2_reg <= addr_s1_reg;
      rd_sync_reg <= {rd_sync_reg[1:0], io_read_n_i};
    end
  end

  // falling edge of read strobe, after two flops
  logic rd_start;
  assign rd_start = rd_sync_reg[2] & ~rd_sync_reg[1];

  // read data is not driven; the cycle is only observed
  assign ev.arm  = rd_start & ((addr_s2_reg == ADDR_ARM_A) | (addr_s2_reg == ADDR_ARM_B));
  assign ev.stop = rd_start & ((addr_s2_reg == ADDR_STOP_A) | (addr_s2_reg == ADDR_STOP_B));
endmodule // iowdt_decode

/* design/iowdt_if.sv */
// interface: decoded host read events between decoder and core
`timescale 1ns/1ns
interface iowdt_if;
  logic arm;
  logic stop;
  modport dec  (output arm, output stop);
  modport core (input arm, input stop);
endinterface

/* design/iowdt_pkg.sv */
// package: constants for the io read watchdog timer
package iowdt_pkg;
  localparam int          CLK_HZ          = 125_000_000;
  localparam int          ADDR_W          = 16;
  localparam logic [15:0] ADDR_ARM_A      = 16'h0533;
  localparam logic [15:0] ADDR_ARM_B      = 16'h0543;
  localparam logic [15:0] ADDR_STOP_A     = 16'h0033;
  localparam logic [15:0] ADDR_STOP_B     = 16'h0343;
  localparam int          SEL_W           = 3;
  localparam int          RANGES          = 8;
  localparam int          BASE_MS         = 500;
  localparam longint      BASE_CYCLES     = longint'(CLK_HZ) / 1000 * BASE_MS;
  localparam int          TICK_W          = 27;
  localparam int          TICKS_W         = 8;
  localparam int          PULSE_CYCLES    = 16;
  localparam int          PULSE_W         = 5;
  typedef enum logic [1:0] {IOWDT_IDLE, IOWDT_RUN, IOWDT_FIRE} iowdt_state_t;
endpackage

/* design/iowdt_top.sv */
// module: io read watchdog timer core
// Functional notes
// - while armed, an expiry without a retrigger asserts system reset, or nmi when routed there; a retrigger prevents it.
// - one of 8 intervals from 500 ms to 64 s is chosen by a static jumper input.
// - a read at 0533h or 0543h arms the idle watchdog or restarts a running count.
// - a read at 0033h or 0343h disarms the watchdog until armed again.
// - a static route jumper steers the expiry to the nmi line instead of reset.
`timescale 1ns/1ns
module iowdt_top
#(
  // clocks per 500 ms unit; only a bench shortens it
  parameter int UNIT_CYCLES = int'(iowdt_pkg::BASE_CYCLES)
)
(
  input  wire logic                         clock_i,
  input  wire logic                         reset_i,
  input  wire logic [iowdt_pkg::ADDR_W-1:0] io_addr_i,
  input  wire logic                         io_read_n_i,
  input  wire logic [iowdt_pkg::SEL_W-1:0]  interval_sel_i,
  input  wire logic                         nmi_route_jumper_i,
  output logic                              sys_reset_o,
  output logic                              nmi_o,
  output logic                              armed_o
);
  import iowdt_pkg::*;

  // jumper bundle: interval select plus route
  localparam int JMP_W = SEL_W + 1;

  // decoded host read events
  iowdt_if ev ();

  iowdt_decode u_decode (
    .clock_i     (clock_i),
    .reset_i     (reset_i),
    .io_addr_i   (io_addr_i),
    .io_read_n_i (io_read_n_i),
    .ev          (ev.dec)
  );

  // static jumpers, still asynchronous to the clock
  logic [JMP_W-1:0] jmp_raw;
  logic [JMP_W-1:0] jmp_sync;
  logic [SEL_W-1:0] sel_sync;
  logic             route_sync;

  assign jmp_raw = {nmi_route_jumper_i, interval_sel_i};

  // two flops per jumper bit
  genvar gi;
  generate
    for (gi = 0; gi < JMP_W; gi++)
    begin : g_jmp_sync
      logic s1_reg;
      logic s2_reg;

      always_ff @(posedge clock_i)
      begin
        if (reset_i)
        begin
          s1_reg <= 1'b0;
          s2_reg <= 1'b0;
        end
        else
        begin
          s1_reg <= jmp_raw[gi];
          s2_reg <= s1_reg;
        end
      end

      assign jmp_sync[gi] = s2_reg;
    end
  endgenerate

  assign sel_sync   = jmp_sync[SEL_W-1:0];
  assign route_sync = jmp_sync[SEL_W];

  // interval length in 500 ms units: 1, 2, 4 .. 128
  function automatic logic [TICKS_W-1:0] ticks_of(input logic [SEL_W-1:0] sel);
    ticks_of = TICKS_W'(1) << sel;
  endfunction

  // watchdog state and counters
  iowdt_state_t       state_reg;
  logic [TICK_W-1:0]  base_reg;
  logic [TICKS_W-1:0] ticks_reg;
  logic [PULSE_W-1:0] pulse_reg;
  logic               running;
  logic               firing;
  logic               base_done;
  logic               last_tick;
  logic               pulse_done;
  logic               expire;

  // one unit passes every UNIT_CYCLES clocks
  assign running    = (state_reg == IOWDT_RUN);
  assign firing     = (state_reg == IOWDT_FIRE);
  assign base_done  = (base_reg == TICK_W'(UNIT_CYCLES - 1));
  assign last_tick  = (ticks_reg >= ticks_of(sel_sync) - TICKS_W'(1));
  assign pulse_done = (pulse_reg == PULSE_W'(PULSE_CYCLES - 1));
  // a retrigger in the final cycle beats the expiry
  assign expire     = running && base_done && last_tick && !ev.arm;

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      state_reg <= IOWDT_IDLE;
    end
    else
    begin
      case (state_reg)
        // arm read starts supervision
        IOWDT_IDLE:
        begin
          if (ev.arm)
            state_reg <= IOWDT_RUN;
        end
        // disarm wins over a pending expiry
        IOWDT_RUN:
        begin
          if (ev.stop)
            state_reg <= IOWDT_IDLE;
          else if (expire)
            state_reg <= IOWDT_FIRE;
        end
        // stop and arm reads are ignored while firing
        IOWDT_FIRE:
        begin
          if (pulse_done)
            state_reg <= IOWDT_IDLE;
        end
        default:
        begin
          state_reg <= IOWDT_IDLE;
        end
      endcase
    end
  end

  // unit prescaler, restarted by every arm read
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      base_reg <= '0;
    end
    else if (!running || ev.arm)
    begin
      base_reg <= '0;
    end
    else if (base_done)
    begin
      base_reg <= '0;
    end
    else
    begin
      base_reg <= base_reg + TICK_W'(1);
    end
  end

  // elapsed units since the last arm read
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      ticks_reg <= '0;
    end
    else if (!running || ev.arm)
    begin
      ticks_reg <= '0;
    end
    else if (base_done)
    begin
      ticks_reg <= ticks_reg + TICKS_W'(1);
    end
  end

  // expiry pulse length
  always_ff @(posedge clock_i)
  begin
    if (reset_i || !firing)
    begin
      pulse_reg <= '0;
    end
    else
    begin
      pulse_reg <= pulse_reg + PULSE_W'(1);
    end
  end

  // reset routing of the expiry
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
      sys_reset_o <= 1'b0;
    else
      sys_reset_o <= firing && !route_sync;
  end

  // nmi routing of the expiry
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
      nmi_o <= 1'b0;
    else
      nmi_o <= firing && route_sync;
  end

  // armed status while counting
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
      armed_o <= 1'b0;
    else
      armed_o <= running;
  end
endmodule // iowdt_top

/* sim/iowdt_chk.sv */
// checker: port assertions for the watchdog
`timescale 1ns/1ns
module iowdt_chk
  import iowdt_pkg::*;
(
  input wire logic              clock_i,
  input wire logic              reset_i,
  input wire logic [ADDR_W-1:0] io_addr_i,
  input wire logic              io_read_n_i,
  input wire logic [SEL_W-1:0]  interval_sel_i,
  input wire logic              nmi_route_jumper_i,
  input wire logic              sys_reset_o,
  input wire logic              nmi_o,
  input wire logic              armed_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  wire logic go = sys_reset_o | nmi_o;
  sequence s_arm;
    $fell(io_read_n_i) && (io_addr_i == ADDR_ARM_A || io_addr_i == ADDR_ARM_B);
  endsequence
  sequence s_stop;
    $fell(io_read_n_i) && (io_addr_i == ADDR_STOP_A || io_addr_i == ADDR_STOP_B);
  endsequence
  chk_arm_on: assert property (s_arm ##0 !go |-> ##[3:6] armed_o)
    else $error("arm lost");
  chk_stop_off: assert property (s_stop |-> ##[3:6] !armed_o)
    else $error("stop lost");
  chk_fire_armed: assert property ($rose(go) |-> $past(armed_o) || $past(armed_o, 2))
    else $error("fire while idle");
  chk_route_rst: assert property ($rose(sys_reset_o) |-> !nmi_route_jumper_i && !nmi_o)
    else $error("bad reset route");
  chk_route_nmi: assert property ($rose(nmi_o) |-> nmi_route_jumper_i)
    else $error("bad nmi route");
  chk_reset_clear: assert property ($fell(reset_i) |-> !armed_o && !go)
    else $error("reset not clean");
  chk_one_route: assert property (!(sys_reset_o && nmi_o))
    else $error("both expiry outputs high");
  chk_pulse_hold: assert property ($rose(go) |-> go[*8])
    else $error("expiry pulse too short");
endmodule // iowdt_chk
bind iowdt_top iowdt_chk u_chk (.clock_i(clock_i), .reset_i(reset_i), .io_addr_i(io_addr_i),
  .io_read_n_i(io_read_n_i), .interval_sel_i(interval_sel_i), .sys_reset_o(sys_reset_o),
  .nmi_route_jumper_i(nmi_route_jumper_i), .nmi_o(nmi_o), .armed_o(armed_o));

/* sim/iowdt_host.sv */
// host model issuing io port reads
`timescale 1ns/1ns
module iowdt_host
  import iowdt_pkg::*;
(
  input  wire logic              clock_i,
  output logic      [ADDR_W-1:0] io_addr_o,
  output logic                   io_read_n_o
);
  initial
  begin
    io_addr_o = '0;
    io_read_n_o = 1'b1;
  end
  // one read cycle, address held around strobe
  task automatic rd(input logic [ADDR_W-1:0] a);
    io_addr_o = a;
    repeat (4) @(negedge clock_i);
    io_read_n_o = 1'b0;
    repeat (4) @(negedge clock_i);
    io_read_n_o = 1'b1;
    io_addr_o = ~a;
    repeat (4) @(negedge clock_i);
  endtask
endmodule // iowdt_host

/* sim/tb_iowdt_top.sv */
// testbench: io read watchdog timer
`timescale 1ns/1ns
module tb_iowdt_top;
  import iowdt_pkg::*;
  localparam int     UNIT  = 40;
  localparam int     LIMIT = 40000;
  logic              clock_i = 1'b0;
  logic              reset_i = 1'b1;
  logic [ADDR_W-1:0] addr;
  logic              rd_n;
  logic [SEL_W-1:0]  sel = 3'h7;
  logic              route = 1'b0;
  logic              srst, nmi, armed;
  int                fail_count = 0;
  int                total_checks = 0;
  int                cycles = 0;
  logic              exp_armed = 1'b0;
  logic [15:0]       tbl [5] = '{ADDR_ARM_A, ADDR_STOP_A, ADDR_ARM_B, ADDR_STOP_B, ADDR_ARM_A};
  always #4 clock_i = ~clock_i;
  iowdt_host host (.clock_i(clock_i), .io_addr_o(addr), .io_read_n_o(rd_n));
  iowdt_top #(.UNIT_CYCLES(UNIT)) dut (.clock_i(clock_i), .reset_i(reset_i), .io_addr_i(addr),
    .io_read_n_i(rd_n),
    .interval_sel_i(sel), .nmi_route_jumper_i(route), .sys_reset_o(srst), .nmi_o(nmi),
    .armed_o(armed));
  task automatic chk(input logic got, input logic exp);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [15:0] a);
    host.rd(a);
    if (a == ADDR_ARM_A || a == ADDR_ARM_B) exp_armed = 1'b1;
    if (a == ADDR_STOP_A || a == ADDR_STOP_B) exp_armed = 1'b0;
    chk(armed, exp_armed);
    chk(srst | nmi, 1'b0);
  endtask
  task automatic expiry(input logic [SEL_W-1:0] s, input logic r);
    int nu;
    nu = (1 << s) * UNIT;
    rd(ADDR_STOP_A);
    sel = s;
    route = r;
    repeat (4) @(negedge clock_i);
    rd(ADDR_ARM_A);
    repeat (nu - 5) @(negedge clock_i);
    chk(armed, 1'b1);
    chk(srst | nmi, 1'b0);
    @(negedge clock_i);
    chk(srst, !r);
    chk(nmi, r);
    chk(armed, 1'b0);
    repeat (15) @(negedge clock_i);
    chk(srst | nmi, 1'b1);
    @(negedge clock_i);
    chk(srst | nmi, 1'b0);
    exp_armed = 1'b0;
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      fail_count++;
      print_verdict();
    end
  end
  initial
  begin
    void'($urandom(32'hdbc5371a));
    repeat (3) @(negedge clock_i);
    reset_i = 1'b0;
    foreach (tbl[i]) rd(tbl[i]);
    $display("test directed done");
    repeat (30)
    begin
      route = 1'($urandom);
      rd($urandom_range(1, 0) ? tbl[$urandom_range(4, 0)] : 16'($urandom));
    end
    $display("test random done");
    rd(ADDR_STOP_B);
    sel = '0;
    repeat (4) @(negedge clock_i);
    repeat (8) rd(ADDR_ARM_B);
    rd(ADDR_STOP_A);
    $display("test retrigger done");
    for (int k = 0; k < 4; k++) expiry(3'($urandom), 1'(k));
    $display("test expiry done");
    rd(ADDR_ARM_B);
    reset_i = 1'b1;
    repeat (3) @(negedge clock_i);
    reset_i = 1'b0;
    @(negedge clock_i);
    chk(armed, 1'b0);
    chk(srst | nmi, 1'b0);
    exp_armed = 1'b0;
    $display("test reset done");
    print_verdict();
  end
endmodule // tb_iowdt_top
